/* txc_fabric.sv */
// Far-side coherence fabric model: records line ownership requests.
// Assumes the bench issues snoops on req in the fabric's place.
`timescale 1ns/1ps
`default_nettype none

module txc_fabric
	import txc_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire txc_own_t own_req,
	output logic [7:0] own_count,
	output logic [TXC_LINE_W-1:0] own_line
);
	// Counting, not just flagging, shows repeated stores each ask again
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			own_count <= 8'h00;
			own_line <= '0;
		end
		else if (own_req.valid)
		begin
			own_count <= own_count + 8'h01;
			own_line <= own_req.line;
		end
	end
endmodule

`default_nettype wire

/* txc_map.svh */
// Constants of the transactional conflict tracker: geometry and encodings.
// Assumes inclusion by every file that needs a constant; the guard allows repeats.
`ifndef TXC_MAP_SVH
`define TXC_MAP_SVH

`define TXC_ADDR_W 32
`define TXC_LINE_BYTES 64
`define TXC_LINE_OFF_W 6
`define TXC_WAYS 8
`define TXC_SETS 64
`define TXC_BLOOM_BITS 256
`define TXC_CAUSE_NONE 2'h0
`define TXC_CAUSE_CONFLICT 2'h1
`define TXC_CAUSE_CAPACITY 2'h2
`define TXC_CAUSE_EXPLICIT 2'h3
`define TXC_SRC_CORE 2'h0
`define TXC_SRC_SIBLING 2'h1
`define TXC_SRC_SNOOP 2'h2
`define TXC_ST_IDLE 2'h0
`define TXC_ST_READ 2'h1
`define TXC_ST_UPDATE 2'h2

`endif

/* txc_pkg.sv */
// Types shared by the conflict tracker and its tag memory.
// Assumes txc_map.svh is on the include path.
`include "txc_map.svh"

package txc_pkg;

	localparam int TXC_LINE_W = `TXC_ADDR_W - `TXC_LINE_OFF_W;

	typedef enum logic [1:0] {
		txc_cause_none = `TXC_CAUSE_NONE,
		txc_cause_conflict = `TXC_CAUSE_CONFLICT,
		txc_cause_capacity = `TXC_CAUSE_CAPACITY,
		txc_cause_explicit = `TXC_CAUSE_EXPLICIT
	} txc_cause_t;

	typedef enum logic [1:0] {
		txc_src_core = `TXC_SRC_CORE,
		txc_src_sibling = `TXC_SRC_SIBLING,
		txc_src_snoop = `TXC_SRC_SNOOP
	} txc_src_t;

	typedef enum logic [1:0] {
		txc_st_idle = `TXC_ST_IDLE,
		txc_st_read = `TXC_ST_READ,
		txc_st_update = `TXC_ST_UPDATE
	} txc_state_t;

	typedef struct packed {
		logic valid;
		txc_src_t src;
		logic write;
		logic [`TXC_ADDR_W-1:0] addr;
	} txc_req_t;

	typedef struct packed {
		logic valid;
		logic [TXC_LINE_W-1:0] line;
	} txc_own_t;

endpackage

/* txc_tag_ram.sv */
// Tag memory of the tracker: one row per cache set, all ways side by side.
// Assumes one clock; read data valid one cycle after rd_en.
`timescale 1ns/1ps
`default_nettype none
`include "txc_map.svh"

module txc_tag_ram
	import txc_pkg::*;
#(
	parameter int DEPTH = `TXC_SETS,
	parameter int WIDTH = 8
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic rd_en,
	input wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data,
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] next_rd_data;

	always_comb
	begin
		next_rd_data = rd_data;
		if (rd_en)
		begin
			next_rd_data = mem[rd_addr];
		end
	end

	// Array has no reset; the tracker keeps way valid bits in flops
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			rd_data <= '0;
		end
		else
		begin
			rd_data <= next_rd_data;
		end
	end

	always_ff @(posedge clock)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

endmodule
`default_nettype wire

/* txc_tracker.sv */
// Read-set and write-set tracker of a transactional region in the L1 data cache.
// Assumes one request at a time on req, raised only while req_ready is high.
// Function
// R1 - Conflicts compared per whole 64-byte line
// R2 - Read and write sets marked in L1
// R3 - Evicted read lines kept in lossy filter
// R4 - Ninth written line in one set aborts
// R5 - No capacity or commit guarantee given
// R6 - Sibling thread evictions shrink tracked sets
// R7 - Every store requests line ownership
// R8 - Query instruction reports transactional state
// R9 - Explicit abort instruction ends transaction
// R10 - Remote read of write-set, remote write conflicts
// R11 - Detecting thread is the one aborting
// R12 - Abort discards writes, clears marks, reports cause
`timescale 1ns/1ps
`default_nettype none
`include "txc_map.svh"

module txc_tracker
	import txc_pkg::*;
#(
	parameter int WAYS = `TXC_WAYS,
	parameter int SETS = `TXC_SETS,
	parameter int BLOOM_BITS = `TXC_BLOOM_BITS
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire txc_req_t req,
	output logic req_ready,
	input wire logic txn_begin,
	input wire logic txn_commit,
	input wire logic explicit_txn_abort_instr,
	input wire logic txn_state_query_instr,
	output logic in_txn,
	output logic query_resp_valid,
	output logic query_in_txn,
	output txc_own_t own_req,
	output logic abort,
	output txc_cause_t abort_cause,
	output logic wr_discard,
	output logic commit_done
);

	localparam int SET_W = $clog2(SETS);
	localparam int WAY_W = $clog2(WAYS);
	localparam int TAG_W = TXC_LINE_W - SET_W;
	localparam int ENT_W = TAG_W + 1;
	localparam int BLOOM_W = $clog2(BLOOM_BITS);

	txc_state_t state, next_state;
	txc_req_t cur, next_cur;
	logic [WAYS-1:0] rd_mark [SETS];
	logic [WAYS-1:0] next_rd_mark [SETS];
	logic [WAYS-1:0] wr_mark [SETS];
	logic [WAYS-1:0] next_wr_mark [SETS];
	// Valid bits in flops: the tag array comes out of reset unknown
	logic [WAYS-1:0] line_valid [SETS];
	logic [WAYS-1:0] next_line_valid [SETS];
	logic [BLOOM_BITS-1:0] bloom, next_bloom;
	logic [WAY_W-1:0] rr, next_rr;
	logic next_ready, next_in_txn, next_query_valid, next_query_in;
	logic next_abort, next_discard, next_commit_done;
	txc_cause_t next_cause;
	txc_own_t next_own;

	logic ram_rd_en, ram_wr_en;
	logic [WAYS*ENT_W-1:0] ram_rd_data, ram_wr_data;
	logic [TXC_LINE_W-1:0] cur_line;
	logic [SET_W-1:0] cur_set;
	logic [TAG_W-1:0] cur_tag;
	logic [WAYS-1:0] way_valid, hit_vec;
	logic [TAG_W-1:0] way_tag [WAYS];
	logic conflict, capacity, hit_any, found;
	logic [WAY_W-1:0] hit_way, victim;

	// Offset bits dropped: disjoint variables in one line look identical
	assign cur_line = cur.addr[`TXC_ADDR_W-1:`TXC_LINE_OFF_W]; // [R1]
	assign cur_set = cur_line[SET_W-1:0];
	assign cur_tag = cur_line[TXC_LINE_W-1:SET_W];

	txc_tag_ram #(
		.DEPTH(SETS),
		.WIDTH(WAYS*ENT_W)
	) u_tags (
		.clock(clock),
		.nrst(nrst),
		.rd_en(ram_rd_en),
		.rd_addr(req.addr[`TXC_LINE_OFF_W +: SET_W]),
		.rd_data(ram_rd_data),
		.wr_en(ram_wr_en),
		.wr_addr(cur_set),
		.wr_data(ram_wr_data)
	);

	for (genvar w = 0; w < WAYS; w++)
	begin : g_way
		assign way_valid[w] = line_valid[cur_set][w];
		assign way_tag[w] = ram_rd_data[w*ENT_W +: TAG_W];
		assign hit_vec[w] = way_valid[w] && (way_tag[w] == cur_tag); // [R1]
	end

	// Lossy fold: aliasing lines give false conflicts, accepted as aborts
	function automatic logic [BLOOM_W-1:0] bloom_idx(input logic [TXC_LINE_W-1:0] line);
		logic [BLOOM_W-1:0] h;
		h = '0;
		for (int i = 0; i < TXC_LINE_W; i++)
		begin
			h[i % BLOOM_W] = h[i % BLOOM_W] ^ line[i];
		end
		return h;
	endfunction

	always_comb
	begin
		next_state = state;
		next_cur = cur;
		next_rd_mark = rd_mark;
		next_wr_mark = wr_mark;
		next_line_valid = line_valid;
		next_bloom = bloom;
		next_rr = rr;
		next_in_txn = in_txn;
		next_abort = 1'b0;
		next_cause = abort_cause;
		next_discard = 1'b0;
		next_commit_done = 1'b0;
		next_own = '0;
		next_query_valid = txn_state_query_instr; // [R8]
		next_query_in = in_txn; // [R8]
		ram_rd_en = 1'b0;
		ram_wr_en = 1'b0;
		ram_wr_data = ram_rd_data;
		conflict = 1'b0;
		capacity = 1'b0;
		hit_any = |hit_vec;
		hit_way = '0;
		victim = rr;
		found = 1'b0;
		for (int w = 0; w < WAYS; w++)
		begin
			if (hit_vec[w])
			begin
				hit_way = WAY_W'(w);
			end
		end
		for (int w = 0; w < WAYS; w++)
		begin
			if (!found && !way_valid[w])
			begin
				victim = WAY_W'(w);
				found = 1'b1;
			end
		end
		// Unmarked ways go before marked ones to delay capacity aborts
		for (int w = 0; w < WAYS; w++)
		begin
			if (!found && !rd_mark[cur_set][w] && !wr_mark[cur_set][w])
			begin
				victim = WAY_W'(w);
				found = 1'b1;
			end
		end
		case (state)
			txc_st_idle:
			begin
				if (req.valid)
				begin
					next_cur = req;
					ram_rd_en = 1'b1;
					next_state = txc_st_read;
				end
			end
			txc_st_read:
			begin
				next_state = txc_st_update;
			end
			txc_st_update:
			begin
				next_state = txc_st_idle;
				if (cur.src == txc_src_snoop)
				begin
					if (hit_any && (wr_mark[cur_set][hit_way]
						|| (cur.write && rd_mark[cur_set][hit_way])))
					begin
						conflict = 1'b1; // [R10]
					end
					if (cur.write && bloom[bloom_idx(cur_line)])
					begin
						conflict = 1'b1; // [R3]
					end
				end
				else
				begin
					if (cur.src == txc_src_core && cur.write)
					begin
						// Even same-value stores take ownership
						next_own.valid = 1'b1; // [R7]
						next_own.line = cur_line;
					end
					if (!hit_any)
					begin
						// Sibling fills share the ways and evict marked lines
						ram_wr_en = 1'b1; // [R6]
						ram_wr_data[victim*ENT_W +: ENT_W] = {1'b1, cur_tag};
						next_line_valid[cur_set][victim] = 1'b1;
						next_rr = rr + 1'b1;
						if (way_valid[victim] && wr_mark[cur_set][victim])
						begin
							capacity = 1'b1; // [R4] [R5]
						end
						else if (way_valid[victim] && rd_mark[cur_set][victim])
						begin
							next_bloom[bloom_idx({way_tag[victim], cur_set})] = 1'b1; // [R3]
						end
						next_rd_mark[cur_set][victim] = 1'b0;
						next_wr_mark[cur_set][victim] = 1'b0;
					end
					if (cur.src == txc_src_core && in_txn)
					begin
						if (cur.write)
						begin
							next_wr_mark[cur_set][hit_any ? hit_way : victim] = 1'b1; // [R2]
						end
						else
						begin
							next_rd_mark[cur_set][hit_any ? hit_way : victim] = 1'b1; // [R2]
						end
					end
				end
			end
			default:
			begin
				next_state = txc_st_idle;
			end
		endcase
		if (txn_begin && !in_txn)
		begin
			next_in_txn = 1'b1;
		end
		if (in_txn && (explicit_txn_abort_instr || conflict || capacity))
		begin
			// This thread found it, so this thread aborts
			next_abort = 1'b1; // [R11]
			if (explicit_txn_abort_instr)
			begin
				next_cause = txc_cause_explicit; // [R9]
			end
			else if (conflict)
			begin
				next_cause = txc_cause_conflict; // [R12]
			end
			else
			begin
				next_cause = txc_cause_capacity; // [R12]
			end
			next_discard = 1'b1; // [R12]
			next_in_txn = 1'b0;
		end
		else if (in_txn && txn_commit)
		begin
			next_commit_done = 1'b1;
			next_in_txn = 1'b0;
		end
		if (next_abort || next_commit_done)
		begin
			next_bloom = '0; // [R12]
			for (int s = 0; s < SETS; s++)
			begin
				next_rd_mark[s] = '0; // [R12]
				next_wr_mark[s] = '0;
			end
		end
		next_ready = (next_state == txc_st_idle);
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= txc_st_idle;
			cur <= '0;
			bloom <= '0;
			rr <= '0;
			req_ready <= 1'b1;
			in_txn <= 1'b0;
			query_resp_valid <= 1'b0;
			query_in_txn <= 1'b0;
			own_req <= '0;
			abort <= 1'b0;
			abort_cause <= txc_cause_none;
			wr_discard <= 1'b0;
			commit_done <= 1'b0;
			for (int s = 0; s < SETS; s++)
			begin
				rd_mark[s] <= '0;
				line_valid[s] <= '0;
				wr_mark[s] <= '0;
			end
		end
		else
		begin
			state <= next_state;
			cur <= next_cur;
			bloom <= next_bloom;
			rr <= next_rr;
			req_ready <= next_ready;
			in_txn <= next_in_txn;
			query_resp_valid <= next_query_valid;
			query_in_txn <= next_query_in;
			own_req <= next_own;
			abort <= next_abort;
			abort_cause <= next_cause;
			wr_discard <= next_discard;
			commit_done <= next_commit_done;
			rd_mark <= next_rd_mark;
			line_valid <= next_line_valid;
			wr_mark <= next_wr_mark;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	sequence s_store_accept;
		req.valid && req_ready && req.src == txc_src_core && req.write;
	endsequence
	sequence s_walk;
		!req_ready ##1 !req_ready ##1 req_ready;
	endsequence

	property p_own_req;
		s_store_accept |-> ##3 own_req.valid
			&& own_req.line == $past(req.addr[`TXC_ADDR_W-1:`TXC_LINE_OFF_W], 3);
	endproperty
	a_own_req: assert property (p_own_req) else $error("store without ownership request"); // [R7]

	property p_explicit;
		explicit_txn_abort_instr && in_txn |=> abort && abort_cause == txc_cause_explicit;
	endproperty
	a_explicit: assert property (p_explicit) else $error("explicit abort not taken"); // [R9]

	property p_query;
		txn_state_query_instr |=> query_resp_valid && query_in_txn == $past(in_txn);
	endproperty
	a_query: assert property (p_query) else $error("query answer wrong"); // [R8]

	property p_abort_exit;
		abort |-> !in_txn && wr_discard && abort_cause != txc_cause_none;
	endproperty
	a_abort_exit: assert property (p_abort_exit) else $error("abort left state behind"); // [R12]

	property p_abort_needs_txn;
		abort |-> $past(in_txn);
	endproperty
	a_abort_needs_txn: assert property (p_abort_needs_txn) else $error("abort outside txn"); // [R11]

	property p_conflict_src;
		abort && abort_cause == txc_cause_conflict && !$past(explicit_txn_abort_instr)
			|-> $past(state == txc_st_update && cur.src == txc_src_snoop);
	endproperty
	a_conflict_src: assert property (p_conflict_src) else $error("conflict without snoop"); // [R10]

	property p_capacity_src;
		abort && abort_cause == txc_cause_capacity
			|-> $past(state == txc_st_update && cur.src != txc_src_snoop && !hit_any);
	endproperty
	a_capacity_src: assert property (p_capacity_src) else $error("capacity without eviction"); // [R4]

	property p_walk;
		req.valid && req_ready |=> s_walk;
	endproperty
	a_walk: assert property (p_walk) else $error("lookup pipeline length wrong"); // [R2]

endmodule
`default_nettype wire

/* txc_tracker_bench.sv */
// Self-checking bench of the conflict tracker with the fabric model.
// Assumes results registered at the second edge after a request is taken.
`timescale 1ns/1ps
`default_nettype none

module txc_tracker_bench;
	import txc_pkg::*;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	txc_req_t req = '0;
	logic [3:0] ctl = 4'h0;
	logic req_ready, in_txn, query_resp_valid, query_in_txn;
	logic abort, wr_discard, commit_done;
	txc_own_t own_req;
	txc_cause_t abort_cause;
	logic [7:0] own_count;
	logic [TXC_LINE_W-1:0] own_line;
	int fails = 0;
	int comparisons = 0;
	int i;

	always #20 clock = ~clock;

	txc_tracker txc_tracker_inst (.clock(clock), .nrst(nrst), .req(req),
		.req_ready(req_ready), .txn_begin(ctl[0]), .txn_commit(ctl[1]),
		.explicit_txn_abort_instr(ctl[2]), .txn_state_query_instr(ctl[3]),
		.in_txn(in_txn), .query_resp_valid(query_resp_valid),
		.query_in_txn(query_in_txn), .own_req(own_req), .abort(abort),
		.abort_cause(abort_cause), .wr_discard(wr_discard),
		.commit_done(commit_done));
	txc_fabric txc_fabric_inst (.clock(clock), .nrst(nrst), .own_req(own_req),
		.own_count(own_count), .own_line(own_line));

	task finish_test;
		begin
			if (fails == 0 && comparisons > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	task ck(input logic [31:0] got, input logic [31:0] exp);
		begin
			comparisons++;
			if (got !== exp)
			begin
				fails++;
				$display("ERROR at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// Request held one edge; result checked 1ns after the second edge that follows
	task txr(input txc_src_t src, input logic wr, input logic [19:0] tag,
		input logic [5:0] set, input logic [5:0] off, input logic ab,
		input txc_cause_t cause);
		begin
			req <= '{1'b1, src, wr, {tag, set, off}};
			@(posedge clock);
			#1;
			req <= '0;
			ck(req_ready, 1'b0);
			repeat (2) @(posedge clock);
			#1;
			ck(req_ready, 1'b1);
			ck(abort, ab);
			ck(wr_discard, ab);
			if (ab)
				ck(abort_cause, cause);
			else
				ck(own_req.valid, wr && src == txc_src_core);
		end
	endtask

	// Leading edge keeps two pulses from colliding in one step
	task pl(input int k);
		begin
			@(posedge clock);
			#1;
			ctl <= 4'h1 << k;
			@(posedge clock);
			#1;
			ctl <= 4'h0;
		end
	endtask

	task t_fill;
		for (i = 0; i < 24; i++)
			txr(txc_src_core, 1'b0, 20'h100 + i % 8, 6'(i / 8), 6'h00, 1'b0, txc_cause_none);
	endtask

	task t_query_store;
		begin
			pl(3);
			ck(query_resp_valid, 1'b1);
			ck(query_in_txn, 1'b0);
			pl(0);
			pl(3);
			ck(query_in_txn, 1'b1);
			txr(txc_src_core, 1'b1, 20'h100, 6'h00, 6'h3c, 1'b0, txc_cause_none);
			txr(txc_src_core, 1'b1, 20'h100, 6'h00, 6'h3c, 1'b0, txc_cause_none);
			pl(2);
			ck(abort, 1'b1);
			ck(abort_cause, txc_cause_explicit);
			ck(wr_discard, 1'b1);
			ck(in_txn, 1'b0);
			// Fabric counts a cycle behind the request, so look after the pulse
			ck(own_count, 8'h02);
			ck(own_line, {20'h100, 6'h00});
		end
	endtask

	task t_conflicts;
		begin
			pl(0);
			txr(txc_src_core, 1'b1, 20'h101, 6'h00, 6'h00, 1'b0, txc_cause_none);
			txr(txc_src_snoop, 1'b0, 20'h101, 6'h00, 6'h20, 1'b1, txc_cause_conflict);
			ck(in_txn, 1'b0);
			pl(0);
			txr(txc_src_core, 1'b0, 20'h100, 6'h01, 6'h00, 1'b0, txc_cause_none);
			txr(txc_src_snoop, 1'b0, 20'h100, 6'h01, 6'h08, 1'b0, txc_cause_none);
			txr(txc_src_snoop, 1'b1, 20'h555, 6'h05, 6'h00, 1'b0, txc_cause_none);
			pl(1);
			ck(commit_done, 1'b1);
			pl(0);
			txr(txc_src_core, 1'b0, 20'h100, 6'h01, 6'h00, 1'b0, txc_cause_none);
			txr(txc_src_snoop, 1'b1, 20'h100, 6'h01, 6'h04, 1'b1, txc_cause_conflict);
		end
	endtask

	task t_capacity;
		begin
			pl(0);
			for (i = 0; i < 8; i++)
				txr(txc_src_core, 1'b1, 20'h200 + i, 6'h00, 6'h00, 1'b0, txc_cause_none);
			txr(txc_src_core, 1'b1, 20'h208, 6'h00, 6'h00, 1'b1, txc_cause_capacity);
			pl(0);
			for (i = 0; i < 8; i++)
				txr(txc_src_core, 1'b1, 20'h300 + i, 6'h01, 6'h00, 1'b0, txc_cause_none);
			txr(txc_src_sibling, 1'b0, 20'h3ff, 6'h01, 6'h00, 1'b1, txc_cause_capacity);
		end
	endtask

	// Eight further fills cycle through every way, so each first line is evicted
	task t_filter;
		begin
			pl(0);
			for (i = 0; i < 16; i++)
				txr(txc_src_core, 1'b0, 20'h400 + i + i / 8 * 8, 6'h02, 6'h00, 1'b0, txc_cause_none);
			txr(txc_src_snoop, 1'b1, 20'h400, 6'h02, 6'h00, 1'b1, txc_cause_conflict);
			pl(2);
			ck(abort, 1'b0);
			pl(1);
			ck(commit_done, 1'b0);
		end
	endtask

	initial
	begin
		repeat (20000) @(posedge clock);
		fails++;
		finish_test();
	end

	initial
	begin
		repeat (6) @(posedge clock);
		#1;
		nrst <= 1'b1;
		t_fill();
		t_query_store();
		t_conflicts();
		t_capacity();
		t_filter();
		finish_test();
	end
endmodule

`default_nettype wire
